// [hdl/slow_control_consts.svh]
// Constants of the slow-control register bank: address map, field positions,
// write masks and reset values.
// Assumes a single logic clock domain and word addressing on the command port.
`ifndef SLOW_CONTROL_CONSTS_SVH
`define SLOW_CONTROL_CONSTS_SVH

// Port widths, control word count and error counter width.
`define SC_ADDR_W 12
`define SC_DATA_W 32
`define SC_CTRL_N 8
`define SC_CNT_W 48

// Control registers occupy eight words from this base.
`define SC_CTRL_BASE 12'h000
`define SC_CTRL_SPAN 12'h007

// Status registers.
`define SC_STAT_CHECK 12'h010
`define SC_STAT_CNT_LO 12'h011
`define SC_STAT_CNT_HI 12'h012
`define SC_STAT_LATCH 12'h013
`define SC_STAT_READOUT 12'h014

// Pulse register and its internally used bit positions.
`define SC_PULSE 12'h020
`define SC_PULSE_CLR_CNT 0
`define SC_PULSE_CLR_LATCH 1

// Memory windows: readout dual-port RAM, FIFO peek window, playback/spy buffer.
`define SC_RAM_BASE 12'h100
`define SC_RAM_SPAN 12'h03F
`define SC_RAM_AW 6
`define SC_FIFO_BASE 12'h200
`define SC_FIFO_SPAN 12'h0FF
`define SC_FIFO_AW 8
`define SC_BUF_BASE 12'h400
`define SC_BUF_SPAN 12'h03F
`define SC_BUF_AW 6

// Writable bits of each control register; other bits stay zero.
`define SC_CTRL_MASK0 32'h0000_0001
`define SC_CTRL_MASK1 32'hFFFF_FFFF
`define SC_CTRL_MASK2 32'h0000_000F
`define SC_CTRL_MASK3 32'hFFFF_FFFF
`define SC_CTRL_MASK4 32'h0000_FFFF
`define SC_CTRL_MASK5 32'h0000_00FF
`define SC_CTRL_MASK6 32'h0000_FFFF
`define SC_CTRL_MASK7 32'h00FF_FFFF

// Power-up value of every register bit.
`define SC_RESET_WORD 32'h0000_0000

`endif

// [hdl/slow_control_pkg.sv]
// Types shared by the slow-control register bank files.
// Assumes slow_control_consts.svh is on the include path.
`include "slow_control_consts.svh"

package slow_control_pkg;

    typedef logic [`SC_DATA_W-1:0] word_t;
    typedef logic [`SC_ADDR_W-1:0] addr_t;
    typedef logic [`SC_CTRL_N-1:0][`SC_DATA_W-1:0] ctrl_array_t;

    // One-hot decode of the region a request falls in.
    typedef enum logic [7:0] {
        REG_NONE = 8'h01,
        REG_CTRL = 8'h02,
        REG_STAT = 8'h04,
        REG_PULSE = 8'h08,
        REG_RAM = 8'h10,
        REG_FIFO = 8'h20,
        REG_BUF = 8'h40,
        REG_CNT = 8'h80
    } region_e;

endpackage

// [hdl/slow_control_dpram.sv]
// Flip-flop dual-port memory used for the readout RAM and the playback/spy buffer.
// Assumes both ports on clk_i; reads are combinational, writes take effect at the edge.
`timescale 1ns/1ps

module slow_control_dpram #(
    parameter int AW = 6,
    parameter int DW = 32
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic a_we_i,
    input wire logic [AW-1:0] a_addr_i,
    input wire logic [DW-1:0] a_wdata_i,
    output logic [DW-1:0] a_rdata_o,
    input wire logic b_we_i,
    input wire logic [AW-1:0] b_addr_i,
    input wire logic [DW-1:0] b_wdata_i,
    output logic [DW-1:0] b_rdata_o
);

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] next_mem [2**AW];

    // Reads see the stored word; a write lands at the next edge.
    assign a_rdata_o = mem[a_addr_i];
    assign b_rdata_o = mem[b_addr_i];

    // Per-entry update; the controller port wins a same-address collision.
    for (genvar i = 0; i < 2**AW; i++) begin : g_entry
        always_comb begin
            next_mem[i] = mem[i];
            if (b_we_i && b_addr_i == AW'(i)) begin
                next_mem[i] = b_wdata_i;
            end
            if (a_we_i && a_addr_i == AW'(i)) begin
                next_mem[i] = a_wdata_i;
            end
        end

        // Entries power up at zero.
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                mem[i] <= '0;
            end else begin
                mem[i] <= next_mem[i];
            end
        end
    end

endmodule // slow_control_dpram

// [hdl/slow_control_register_bank.sv]
// Slow-control register bank: control, status and pulse registers plus memory windows.
// Assumes an upstream register-protocol decoder drives the request port on clk_i.
//
// Summary of operation
// - Every register and window answers reads; nothing is write-only.
// - Status registers ignore writes; counter and latch also clear through the pulse register.
// - Control registers change only by controller writes.
// - Reading a control register returns the writable bits of its last written value.
// - Writing the pulse register pulses each bit written as one.
// - The pulse register always reads as zero.
// - Writes to read-only or undefined bits change nothing and have no effect.
// - Live counter reads are coherent; high word is a snapshot taken at low read.
// - All register bits power up at zero.
// - The readout dual-port RAM is reachable through the request port.
// - FIFO entries are peeked at any position without popping.
// - The playback/spy buffer is mapped as read/write memory.
`timescale 1ns/1ps
`include "slow_control_consts.svh"

module slow_control_register_bank
    import slow_control_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [`SC_ADDR_W-1:0] req_addr_i,
    input wire logic [`SC_DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic resp_valid_o,
    output logic resp_error_o,
    output logic [`SC_DATA_W-1:0] resp_rdata_o,
    output logic [`SC_CTRL_N-1:0][`SC_DATA_W-1:0] ctrl_o,
    output logic [`SC_DATA_W-1:0] pulse_o,
    input wire logic [`SC_DATA_W-1:0] err_check_i,
    input wire logic err_event_i,
    input wire logic [`SC_DATA_W-1:0] err_flags_i,
    input wire logic [`SC_DATA_W-1:0] readout_status_i,
    input wire logic ram_we_i,
    input wire logic [`SC_RAM_AW-1:0] ram_addr_i,
    input wire logic [`SC_DATA_W-1:0] ram_wdata_i,
    output logic [`SC_DATA_W-1:0] ram_rdata_o,
    output logic [`SC_FIFO_AW-1:0] fifo_peek_addr_o,
    input wire logic [`SC_DATA_W-1:0] fifo_peek_data_i,
    input wire logic spy_we_i,
    input wire logic [`SC_BUF_AW-1:0] buf_addr_i,
    input wire logic [`SC_DATA_W-1:0] spy_wdata_i,
    output logic [`SC_DATA_W-1:0] playback_data_o
);

    localparam ctrl_array_t CTRL_MASK = {`SC_CTRL_MASK7, `SC_CTRL_MASK6, `SC_CTRL_MASK5,
        `SC_CTRL_MASK4, `SC_CTRL_MASK3, `SC_CTRL_MASK2, `SC_CTRL_MASK1, `SC_CTRL_MASK0};

    region_e region;
    logic wr;
    logic rd;
    ctrl_array_t ctrl;
    ctrl_array_t next_ctrl;
    word_t pulse;
    word_t next_pulse;
    logic [`SC_CNT_W-1:0] err_cnt;
    logic [`SC_CNT_W-1:0] next_err_cnt;
    logic [`SC_CNT_W-`SC_DATA_W-1:0] cnt_hi_snap;
    logic [`SC_CNT_W-`SC_DATA_W-1:0] next_cnt_hi_snap;
    word_t err_latch;
    word_t next_err_latch;
    logic resp_valid;
    logic next_resp_valid;
    logic resp_error;
    logic next_resp_error;
    word_t resp_rdata;
    word_t next_resp_rdata;
    word_t ram_a_rdata;
    word_t ram_b_rdata;
    word_t buf_a_rdata;
    word_t buf_b_rdata;
    word_t ram_rdata;
    word_t playback_data;

    // The bank never stalls; every request of the register protocol is taken.
    assign req_ready_o = 1'b1;
    assign wr = req_valid_i && req_write_i;
    assign rd = req_valid_i && !req_write_i;

    // Address decode into one region per request.
    always_comb begin
        region = REG_NONE;
        if ((req_addr_i & ~`SC_CTRL_SPAN) == `SC_CTRL_BASE) begin
            region = REG_CTRL;
        end else if (req_addr_i == `SC_STAT_CNT_LO || req_addr_i == `SC_STAT_CNT_HI) begin
            region = REG_CNT;
        end else if (req_addr_i == `SC_STAT_CHECK || req_addr_i == `SC_STAT_LATCH ||
                     req_addr_i == `SC_STAT_READOUT) begin
            region = REG_STAT;
        end else if (req_addr_i == `SC_PULSE) begin
            region = REG_PULSE;
        end else if ((req_addr_i & ~`SC_RAM_SPAN) == `SC_RAM_BASE) begin
            region = REG_RAM;
        end else if ((req_addr_i & ~`SC_FIFO_SPAN) == `SC_FIFO_BASE) begin
            region = REG_FIFO;
        end else if ((req_addr_i & ~`SC_BUF_SPAN) == `SC_BUF_BASE) begin
            region = REG_BUF;
        end
    end

    // Control registers: only controller writes, masked to the defined bits.
    for (genvar i = 0; i < `SC_CTRL_N; i++) begin : g_ctrl
        always_comb begin
            next_ctrl[i] = ctrl[i];
            if (wr && region == REG_CTRL && req_addr_i[2:0] == 3'(i)) begin
                next_ctrl[i] = (req_wdata_i & CTRL_MASK[i]) |
                    (ctrl[i] & ~CTRL_MASK[i]);
            end
        end
    end

    // Pulse register: written ones become a single-cycle strobe, then drop.
    always_comb begin
        next_pulse = '0;
        if (wr && region == REG_PULSE) begin
            next_pulse = req_wdata_i;
        end
    end

    // Hardware-owned status: error counter and sticky error flags; an event wins over a clear.
    always_comb begin
        next_err_cnt = err_cnt + `SC_CNT_W'(err_event_i);
        if (pulse[`SC_PULSE_CLR_CNT]) begin
            next_err_cnt = `SC_CNT_W'(err_event_i);
        end
        next_err_latch = err_latch | err_flags_i;
        if (pulse[`SC_PULSE_CLR_LATCH]) begin
            next_err_latch = err_flags_i;
        end
        next_cnt_hi_snap = cnt_hi_snap;
        if (rd && req_addr_i == `SC_STAT_CNT_LO) begin
            next_cnt_hi_snap = err_cnt[`SC_CNT_W-1:`SC_DATA_W];
        end
    end

    // FIFO peek index follows the request address; nothing pops an entry.
    assign fifo_peek_addr_o = req_addr_i[`SC_FIFO_AW-1:0];

    // Read answer: one cycle after the request, for reads and writes alike.
    always_comb begin
        next_resp_valid = req_valid_i;
        next_resp_error = req_valid_i && region == REG_NONE;
        next_resp_rdata = '0;
        if (rd) begin
            case (region)
                REG_CTRL: next_resp_rdata = ctrl[req_addr_i[2:0]];
                REG_CNT: begin
                    if (req_addr_i == `SC_STAT_CNT_LO) begin
                        next_resp_rdata = err_cnt[`SC_DATA_W-1:0];
                    end else begin
                        next_resp_rdata = `SC_DATA_W'(cnt_hi_snap);
                    end
                end
                REG_STAT: begin
                    if (req_addr_i == `SC_STAT_CHECK) begin
                        next_resp_rdata = err_check_i;
                    end else if (req_addr_i == `SC_STAT_LATCH) begin
                        next_resp_rdata = err_latch;
                    end else begin
                        next_resp_rdata = readout_status_i;
                    end
                end
                REG_PULSE: next_resp_rdata = '0;
                REG_RAM: next_resp_rdata = ram_a_rdata;
                REG_FIFO: next_resp_rdata = fifo_peek_data_i;
                REG_BUF: next_resp_rdata = buf_a_rdata;
                default: next_resp_rdata = '0;
            endcase
        end
    end

    // Readout-path RAM: controller on port A, readout logic on port B.
    slow_control_dpram #(
        .AW(`SC_RAM_AW),
        .DW(`SC_DATA_W)
    ) u_readout_ram (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .a_we_i(wr && region == REG_RAM),
        .a_addr_i(req_addr_i[`SC_RAM_AW-1:0]),
        .a_wdata_i(req_wdata_i),
        .a_rdata_o(ram_a_rdata),
        .b_we_i(ram_we_i),
        .b_addr_i(ram_addr_i),
        .b_wdata_i(ram_wdata_i),
        .b_rdata_o(ram_b_rdata)
    );

    // Playback/spy buffer: controller on port A, spy capture and playback on port B.
    slow_control_dpram #(
        .AW(`SC_BUF_AW),
        .DW(`SC_DATA_W)
    ) u_playback_buf (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .a_we_i(wr && region == REG_BUF),
        .a_addr_i(req_addr_i[`SC_BUF_AW-1:0]),
        .a_wdata_i(req_wdata_i),
        .a_rdata_o(buf_a_rdata),
        .b_we_i(spy_we_i),
        .b_addr_i(buf_addr_i),
        .b_wdata_i(spy_wdata_i),
        .b_rdata_o(buf_b_rdata)
    );

    // All state registers; every bit powers up at zero.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl <= '0;
            pulse <= '0;
            err_cnt <= '0;
            cnt_hi_snap <= '0;
            err_latch <= '0;
            resp_valid <= 1'b0;
            resp_error <= 1'b0;
            resp_rdata <= '0;
            ram_rdata <= '0;
            playback_data <= '0;
        end else begin
            ctrl <= next_ctrl;
            pulse <= next_pulse;
            err_cnt <= next_err_cnt;
            cnt_hi_snap <= next_cnt_hi_snap;
            err_latch <= next_err_latch;
            resp_valid <= next_resp_valid;
            resp_error <= next_resp_error;
            resp_rdata <= next_resp_rdata;
            ram_rdata <= ram_b_rdata;
            playback_data <= buf_b_rdata;
        end
    end

    // Outputs straight from flops.
    assign ctrl_o = ctrl;
    assign pulse_o = pulse;
    assign resp_valid_o = resp_valid;
    assign resp_error_o = resp_error;
    assign resp_rdata_o = resp_rdata;
    assign ram_rdata_o = ram_rdata;
    assign playback_data_o = playback_data;

endmodule // slow_control_register_bank

// [verification/slow_control_register_bank_monitor.sv]
// Port checker for the slow-control register bank.
// Assumes it is bound to the bank; everything runs on clk_i with reset_i async high.
`timescale 1ns/1ps
`include "slow_control_consts.svh"
module slow_control_register_bank_monitor
    import slow_control_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [`SC_ADDR_W-1:0] req_addr_i,
    input wire logic [`SC_DATA_W-1:0] req_wdata_i,
    input wire logic req_ready_o,
    input wire logic resp_valid_o,
    input wire logic resp_error_o,
    input wire logic [`SC_DATA_W-1:0] resp_rdata_o,
    input wire logic [`SC_CTRL_N-1:0][`SC_DATA_W-1:0] ctrl_o,
    input wire logic [`SC_DATA_W-1:0] pulse_o,
    input wire logic [`SC_DATA_W-1:0] fifo_peek_data_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic wr;
    logic rd;
    logic ctl;
    word_t wexp_q;
    word_t rexp_q;
    logic [2:0] idx_q;
    // Writable bits of each control word.
    function automatic word_t cmask(input logic [2:0] i);
        word_t m [8] = '{`SC_CTRL_MASK0, `SC_CTRL_MASK1, `SC_CTRL_MASK2, `SC_CTRL_MASK3,
            `SC_CTRL_MASK4, `SC_CTRL_MASK5, `SC_CTRL_MASK6, `SC_CTRL_MASK7};
        return m[i];
    endfunction
    // Request decode used by the properties.
    assign wr = req_valid_i && req_write_i;
    assign rd = req_valid_i && !req_write_i;
    assign ctl = req_addr_i <= `SC_CTRL_SPAN;
    // Remembers what a control access should yield one cycle later.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            idx_q <= '0;
            wexp_q <= '0;
            rexp_q <= '0;
        end else begin
            idx_q <= req_addr_i[2:0];
            wexp_q <= req_wdata_i & cmask(req_addr_i[2:0]);
            rexp_q <= ctrl_o[req_addr_i[2:0]];
        end
    end
    a_ready_high: assert property (req_ready_o)
        else $error("ready dropped");
    a_resp_follows: assert property (req_valid_i |=> resp_valid_o)
        else $error("request not answered");
    a_no_spurious: assert property (!req_valid_i |=> !resp_valid_o)
        else $error("answer without request");
    a_pulse_echo: assert property (wr && req_addr_i == `SC_PULSE |=>
        pulse_o == $past(req_wdata_i))
        else $error("pulse bits wrong");
    a_pulse_single: assert property (!(wr && req_addr_i == `SC_PULSE) |=> pulse_o == '0)
        else $error("pulse too long");
    a_pulse_zero: assert property (rd && req_addr_i == `SC_PULSE |=> resp_rdata_o == '0)
        else $error("pulse word read nonzero");
    a_ctrl_held: assert property (!(wr && ctl) |=> $stable(ctrl_o))
        else $error("control changed without write");
    a_ctrl_write: assert property (wr && ctl |=> ctrl_o[idx_q] == wexp_q)
        else $error("control write wrong");
    a_ctrl_read: assert property (rd && ctl |=> resp_rdata_o == rexp_q)
        else $error("control readback wrong");
    a_unmapped_err: assert property (req_valid_i && req_addr_i == 12'h030 |=>
        resp_error_o && resp_rdata_o == '0)
        else $error("unmapped access not refused");
    a_fifo_peek: assert property (rd && req_addr_i[11:8] == 4'h2 |=>
        resp_rdata_o == $past(fifo_peek_data_i))
        else $error("fifo peek wrong");
endmodule // slow_control_register_bank_monitor

// [verification/fifo_store_model.sv]
// Storage of the readout FIFO as seen through its peek port.
// Assumes the index comes from the bank; data is returned in the same cycle.
`timescale 1ns/1ps
module fifo_store_model (
    input wire logic [7:0] peek_addr_i,
    output logic [31:0] peek_data_o
);
    // Each entry holds a known pattern; peeking never removes it.
    assign peek_data_o = {24'hA5C3E1, peek_addr_i};
endmodule // fifo_store_model

// [verification/tb.sv]
// Self-checking bench for the slow-control register bank.
// Assumes the design files and slow_control_consts.svh are compiled first.
`timescale 1ns/1ps
`include "slow_control_consts.svh"
module tb;
    import slow_control_pkg::*;
    logic clk_i = 0, reset_i = 1, req_valid_i = 0, req_write_i = 0, resp_valid_o, resp_error_o;
    logic req_ready_o, err_event_i = 0, ram_we_i = 0, spy_we_i = 0;
    addr_t req_addr_i = '0;
    word_t req_wdata_i = '0, resp_rdata_o, pulse_o, ram_rdata_o, playback_data_o, fifo_peek_data_i;
    word_t err_check_i = '0, err_flags_i = '0, readout_status_i = '0, ram_wdata_i = '0;
    word_t spy_wdata_i = '0, rdat, d, sh [8], seed = 32'h9879C992;
    logic [5:0] ram_addr_i = '0, buf_addr_i = '0, a, b;
    logic [7:0] fifo_peek_addr_o;
    ctrl_array_t ctrl_o;
    logic rerr;
    int err_count = 0, num_checks = 0, cyc = 0, i;
    slow_control_register_bank dut (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o), .resp_error_o(resp_error_o),
        .resp_rdata_o(resp_rdata_o), .ctrl_o(ctrl_o), .pulse_o(pulse_o), .err_check_i(err_check_i),
        .err_event_i(err_event_i), .err_flags_i(err_flags_i), .readout_status_i(readout_status_i),
        .ram_we_i(ram_we_i), .ram_addr_i(ram_addr_i), .ram_wdata_i(ram_wdata_i),
        .ram_rdata_o(ram_rdata_o), .fifo_peek_addr_o(fifo_peek_addr_o),
        .fifo_peek_data_i(fifo_peek_data_i), .spy_we_i(spy_we_i), .buf_addr_i(buf_addr_i),
        .spy_wdata_i(spy_wdata_i), .playback_data_o(playback_data_o));
    fifo_store_model fifo (.peek_addr_i(fifo_peek_addr_o), .peek_data_o(fifo_peek_data_i));
    // Clock at 125 MHz and a cycle ceiling that cuts a hang short.
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            results();
        end
    end
    // Next pseudo-random word.
    function automatic word_t rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Writable bits of each control word.
    function automatic word_t cmask(input int k);
        word_t m [8] = '{`SC_CTRL_MASK0, `SC_CTRL_MASK1, `SC_CTRL_MASK2, `SC_CTRL_MASK3,
            `SC_CTRL_MASK4, `SC_CTRL_MASK5, `SC_CTRL_MASK6, `SC_CTRL_MASK7};
        return m[k];
    endfunction
    // One request, held until the taking edge; answer captured after that edge.
    task automatic txn(input logic w, input addr_t ad, input word_t wd);
        @(posedge clk_i);
        #1 {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, w, ad, wd};
        @(posedge clk_i);
        #1 rdat = resp_rdata_o;
        rerr = resp_error_o;
        req_valid_i = 0;
    endtask
    // Compares one word.
    task automatic chk(input word_t got, input word_t exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        #1 reset_i = 0;
        for (i = 0; i < 8; i++) begin
            txn(0, i, '0);
            chk(rdat, '0);
        end
        txn(0, `SC_STAT_CNT_LO, '0);
        chk(rdat, '0);
        $display("test reset done");
        // All-ones to every word first, then random words at random places.
        for (i = 0; i < 40; i++) begin
            a = (i < 8) ? i : rnd();
            d = (i < 8) ? '1 : rnd();
            txn(1, a[2:0], d);
            sh[a[2:0]] = d & cmask(a[2:0]);
            chk(ctrl_o[a[2:0]], sh[a[2:0]]);
            txn(0, a[2:0], '0);
            chk(rdat, sh[a[2:0]]);
        end
        $display("test control done");
        for (i = 0; i < 6; i++) begin
            d = rnd() & 32'hFFFF_FFFC;
            txn(1, `SC_PULSE, d);
            chk(pulse_o, d);
            @(posedge clk_i);
            #1 chk(pulse_o, '0);
            txn(0, `SC_PULSE, '0);
            chk(rdat, '0);
        end
        $display("test pulse done");
        d = rnd();
        readout_status_i = d;
        err_check_i = ~d;
        txn(1, `SC_STAT_READOUT, ~d);
        txn(0, `SC_STAT_READOUT, '0);
        chk(rdat, d);
        txn(0, `SC_STAT_CHECK, '0);
        chk(rdat, ~d);
        txn(0, 12'h030, '0);
        chk({31'b0, rerr}, 32'h1);
        $display("test status done");
        @(posedge clk_i);
        #1 err_event_i = 1;
        repeat (5) @(posedge clk_i);
        #1 err_event_i = 0;
        err_flags_i = 32'h0000_0100;
        @(posedge clk_i);
        #1 err_flags_i = '0;
        txn(0, `SC_STAT_CNT_LO, '0);
        chk(rdat, 32'h5);
        txn(0, `SC_STAT_CNT_HI, '0);
        chk(rdat, '0);
        txn(0, `SC_STAT_LATCH, '0);
        chk(rdat, 32'h0000_0100);
        // A controller write to the counter must leave it untouched.
        txn(1, `SC_STAT_CNT_LO, '1);
        txn(0, `SC_STAT_CNT_LO, '0);
        chk(rdat, 32'h5);
        txn(1, `SC_PULSE, 32'h3);
        txn(0, `SC_STAT_CNT_LO, '0);
        chk(rdat, '0);
        txn(0, `SC_STAT_LATCH, '0);
        chk(rdat, '0);
        // An event in the very cycle of a counter clear must still be counted.
        txn(1, `SC_PULSE, 32'h1);
        err_event_i = 1;
        @(posedge clk_i);
        #1 err_event_i = 0;
        txn(0, `SC_STAT_CNT_LO, '0);
        chk(rdat, 32'h1);
        $display("test counter done");
        for (i = 0; i < 4; i++) begin
            a = rnd();
            d = rnd();
            @(posedge clk_i);
            #1 {ram_we_i, spy_we_i, ram_addr_i, buf_addr_i} = {2'b11, a, a};
            {ram_wdata_i, spy_wdata_i} = {d, ~d};
            @(posedge clk_i);
            #1 {ram_we_i, spy_we_i} = 2'b00;
            txn(0, `SC_RAM_BASE + a, '0);
            chk(rdat, d);
            txn(0, `SC_BUF_BASE + a, '0);
            chk(rdat, ~d);
            // Neighbouring entry wraps inside the window at the top address.
            b = a + 6'd1;
            txn(1, `SC_RAM_BASE + b, d ^ 32'h5A);
            txn(1, `SC_BUF_BASE + b, d ^ 32'hA5);
            {ram_addr_i, buf_addr_i} = {b, b};
            @(posedge clk_i);
            #1 chk(ram_rdata_o, d ^ 32'h5A);
            chk(playback_data_o, d ^ 32'hA5);
            a = rnd();
            txn(0, `SC_FIFO_BASE + a, '0);
            chk(rdat, {24'hA5C3E1, 2'b00, a});
            txn(0, `SC_FIFO_BASE + a, '0);
            chk(rdat, {24'hA5C3E1, 2'b00, a});
        end
        $display("test memory done");
        results();
    end
endmodule // tb

bind slow_control_register_bank slow_control_register_bank_monitor mon (.clk_i(clk_i),
    .reset_i(reset_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
    .resp_valid_o(resp_valid_o), .resp_error_o(resp_error_o), .resp_rdata_o(resp_rdata_o),
    .ctrl_o(ctrl_o), .pulse_o(pulse_o), .fifo_peek_data_i(fifo_peek_data_i));
